/* hw/sbmc_top.sv */
// Status byte, common commands and measurement query interpreter
`timescale 1ns/1ns
`include "sbmc_consts.svh"

// What this block does
// - Status query returns whole summary byte
// - Reading status byte leaves it unchanged
// - Bit 0 shows measurement event
// - Bit 2 shows error queue nonempty
// - Bit 3 shows questionable event
// - Bit 4 shows response awaiting transfer
// - Bit 5 shows enabled standard event
// - Bit 6 is request service summary
// - Bit 7 shows enabled operation event
// - Trigger takes one averaged displayed reading
// - Self-test returns 0 pass, 1 fail
// - Fetch returns stored result, no measurement
// - Fetch leaves configuration unchanged
// - Read measures; array sized by average count
// - Long integration array size is one
// - Measure selects function then reads
// - Measure without function keeps current function
// - Service request when enabled bit set
// - Hold commands while acquiring, except device clear
module sbmc_top #(
    parameter int AVG_W = 7
) (
    input  wire logic                CLOCK,
    input  wire logic                RSTN,
    input  wire sbmc_pkg::sbmc_req_t REQ,
    input  wire logic                REQ_VALID,
    input  wire sbmc_pkg::sbmc_evt_t EVT,
    input  wire logic [AVG_W-1:0]    AVG_COUNT,
    input  wire logic                ROM_FAIL,
    input  wire logic                ADC_DONE,
    input  wire logic [31:0]         ADC_DATA,
    input  wire logic                TALK,
    output logic                     REQ_READY,
    output logic                     ADC_START,
    output logic                     DISP_STROBE,
    output sbmc_pkg::sbmc_fn_t       FUNC_SEL,
    output sbmc_pkg::sbmc_resp_t     RESP,
    output logic [7:0]               STATUS_BYTE,
    output logic                     SRQ
);
    // ----------------------------------------
    // State record
    // ----------------------------------------
    typedef struct packed {
        sbmc_pkg::sbmc_state_t st;
        sbmc_pkg::sbmc_fn_t    fn;
        logic [7:0]            sre;
        logic [AVG_W-1:0]      size;
        logic [AVG_W-1:0]      cnt;
        logic [31:0]           acc;
        logic [31:0]           last_avg;
        logic                  resp_arr;
        logic                  resp_tst;
        logic                  fetch;
        logic                  trg_only;
        logic [31:0]           qdata;
        logic                  mav;
        logic                  tst_code;
        logic [AVG_W-1:0]      ridx;
        logic                  start;
        logic                  disp;
        logic                  ready;
        sbmc_pkg::sbmc_resp_t  resp;
        logic [7:0]            stb;
        logic                  srq;
    } sbmc_state_rec_t;

    sbmc_state_rec_t  s_r;
    sbmc_state_rec_t  s_nxt;
    logic [31:0]      arr_r [0:(1<<AVG_W)-1];
    logic [7:0]       stb_comb;
    logic             talk_m;
    logic             talk_s;
    logic             is_bypass;
    logic [AVG_W-1:0] eff_size;
    sbmc_pkg::sbmc_fn_t new_fn;

    // ----------------------------------------
    // Talk synchroniser
    // ----------------------------------------
    always_ff @(posedge CLOCK)
    begin
        if (!RSTN)
        begin
            talk_m <= 1'b0;
            talk_s <= 1'b0;
        end
        else
        begin
            talk_m <= TALK;
            talk_s <= talk_m;
        end
    end

    // ----------------------------------------
    // Summary byte
    // ----------------------------------------
    sbmc_summary u_sum (
        .evt (EVT),
        .mav (s_r.mav),
        .sre (s_r.sre),
        .stb (stb_comb)
    );

    assign is_bypass = (REQ.cmd == sbmc_pkg::CMD_DCL) || (REQ.cmd == sbmc_pkg::CMD_TRG);
    // Size follows the function the request leaves selected
    always_comb
    begin
        if ((REQ.cmd == sbmc_pkg::CMD_MEAS || REQ.cmd == sbmc_pkg::CMD_MEAS_ARR)
            && REQ.fn != sbmc_pkg::FN_KEEP)
            new_fn = REQ.fn;
        else
            new_fn = s_r.fn;
        if (new_fn == sbmc_pkg::FN_LINT || AVG_COUNT == '0)
            eff_size = AVG_W'(`SBMC_LINT_SIZE);
        else
            eff_size = AVG_COUNT;
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        s_nxt       = s_r;
        s_nxt.start = 1'b0;
        s_nxt.disp  = 1'b0;
        s_nxt.resp  = '0;
        s_nxt.stb   = stb_comb;
        s_nxt.srq   = stb_comb[`SBMC_BIT_RQS];
        s_nxt.ready = (s_r.st == sbmc_pkg::ST_IDLE);
        case (s_r.st)
            sbmc_pkg::ST_IDLE:
            begin
                if (REQ_VALID && !s_r.mav)
                begin
                    case (REQ.cmd)
                        sbmc_pkg::CMD_SRE:
                            s_nxt.sre = REQ.arg & `SBMC_SRE_MASK;
                        sbmc_pkg::CMD_STB:
                        begin
                            s_nxt.qdata    = {24'h0, stb_comb};
                            s_nxt.resp_arr = 1'b0;
                            s_nxt.resp_tst = 1'b1;
                            s_nxt.mav      = 1'b1;
                        end
                        sbmc_pkg::CMD_TST:
                        begin
                            s_nxt.qdata    = ROM_FAIL ? `SBMC_TST_FAIL : `SBMC_TST_PASS;
                            s_nxt.resp_arr = 1'b0;
                            s_nxt.resp_tst = 1'b1;
                            s_nxt.mav      = 1'b1;
                        end
                        sbmc_pkg::CMD_WAI:
                            s_nxt = s_nxt;
                        sbmc_pkg::CMD_FETCH, sbmc_pkg::CMD_FETCH_ARR:
                        begin
                            s_nxt.resp_arr = (REQ.cmd == sbmc_pkg::CMD_FETCH_ARR);
                            s_nxt.resp_tst = 1'b0;
                            s_nxt.mav      = 1'b1;
                            s_nxt.ridx     = '0;
                        end
                        sbmc_pkg::CMD_TRG, sbmc_pkg::CMD_READ, sbmc_pkg::CMD_READ_ARR,
                        sbmc_pkg::CMD_MEAS, sbmc_pkg::CMD_MEAS_ARR:
                        begin
                            if ((REQ.cmd == sbmc_pkg::CMD_MEAS || REQ.cmd == sbmc_pkg::CMD_MEAS_ARR)
                                && REQ.fn != sbmc_pkg::FN_KEEP)
                                s_nxt.fn = REQ.fn;
                            s_nxt.size     = eff_size;
                            s_nxt.cnt      = '0;
                            s_nxt.acc      = '0;
                            s_nxt.trg_only = (REQ.cmd == sbmc_pkg::CMD_TRG);
                            s_nxt.resp_arr = (REQ.cmd == sbmc_pkg::CMD_READ_ARR)
                                          || (REQ.cmd == sbmc_pkg::CMD_MEAS_ARR);
                            s_nxt.start    = 1'b1;
                            s_nxt.ready    = 1'b0;
                            s_nxt.st       = sbmc_pkg::ST_ACQ;
                        end
                        default:
                            s_nxt = s_nxt;
                    endcase
                end
                else if (REQ_VALID && REQ.cmd == sbmc_pkg::CMD_DCL)
                    s_nxt.mav = 1'b0;
                else if (s_r.mav)
                    s_nxt.st = sbmc_pkg::ST_RESP;
            end
            sbmc_pkg::ST_ACQ:
            begin
                if (REQ_VALID && REQ.cmd == sbmc_pkg::CMD_DCL && is_bypass)
                begin
                    s_nxt.st  = sbmc_pkg::ST_IDLE;
                    s_nxt.mav = 1'b0;
                end
                else if (ADC_DONE)
                begin
                    s_nxt.acc = s_r.acc + ADC_DATA;
                    s_nxt.cnt = s_r.cnt + 1'b1;
                    if (s_r.cnt + 1'b1 == s_r.size)
                    begin
                        s_nxt.last_avg = (s_r.acc + ADC_DATA) / 32'(s_r.size);
                        s_nxt.disp     = 1'b1;
                        s_nxt.resp_tst = 1'b0;
                        s_nxt.ridx     = '0;
                        s_nxt.mav      = !s_r.trg_only;
                        s_nxt.st       = s_r.trg_only ? sbmc_pkg::ST_IDLE : sbmc_pkg::ST_RESP;
                    end
                    else
                        s_nxt.start = 1'b1;
                end
            end
            sbmc_pkg::ST_RESP:
            begin
                if (REQ_VALID && REQ.cmd == sbmc_pkg::CMD_DCL)
                begin
                    s_nxt.mav = 1'b0;
                    s_nxt.st  = sbmc_pkg::ST_IDLE;
                end
                else if (talk_s)
                begin
                    s_nxt.resp.valid = 1'b1;
                    if (s_r.resp_tst)
                        s_nxt.resp.data = s_r.qdata;
                    else if (s_r.resp_arr)
                        s_nxt.resp.data = arr_r[s_r.ridx];
                    else
                        s_nxt.resp.data = s_r.last_avg;
                    if (!s_r.resp_arr || s_r.resp_tst || s_r.ridx + 1'b1 == s_r.size)
                    begin
                        s_nxt.resp.last = 1'b1;
                        s_nxt.mav       = 1'b0;
                        s_nxt.st        = sbmc_pkg::ST_IDLE;
                    end
                    else
                        s_nxt.ridx = s_r.ridx + 1'b1;
                end
            end
            default:
                s_nxt.st = sbmc_pkg::ST_IDLE;
        endcase
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge CLOCK)
    begin
        if (!RSTN)
        begin
            s_r      <= '0;
            s_r.st   <= sbmc_pkg::ST_IDLE;
            s_r.fn   <= sbmc_pkg::FN_VOLT;
            s_r.sre  <= `SBMC_SRE_RESET;
            s_r.size <= `SBMC_AVG_RESET;
        end
        else
            s_r <= s_nxt;
    end

    always_ff @(posedge CLOCK)
    begin
        if (s_r.st == sbmc_pkg::ST_ACQ && ADC_DONE)
            arr_r[s_r.cnt] <= ADC_DATA;
    end

    assign REQ_READY   = s_r.ready;
    assign ADC_START   = s_r.start;
    assign DISP_STROBE = s_r.disp;
    assign FUNC_SEL    = s_r.fn;
    assign RESP        = s_r.resp;
    assign STATUS_BYTE = s_r.stb;
    assign SRQ         = s_r.srq;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence fetch_req_s;
        REQ_VALID && s_r.st == sbmc_pkg::ST_IDLE && !s_r.mav
            && (REQ.cmd == sbmc_pkg::CMD_FETCH || REQ.cmd == sbmc_pkg::CMD_FETCH_ARR);
    endsequence

    sequence trg_req_s;
        REQ_VALID && s_r.st == sbmc_pkg::ST_IDLE && !s_r.mav
            && REQ.cmd == sbmc_pkg::CMD_TRG;
    endsequence

    sequence read_req_s;
        REQ_VALID && s_r.st == sbmc_pkg::ST_IDLE && !s_r.mav
            && (REQ.cmd == sbmc_pkg::CMD_READ || REQ.cmd == sbmc_pkg::CMD_READ_ARR
                || REQ.cmd == sbmc_pkg::CMD_MEAS || REQ.cmd == sbmc_pkg::CMD_MEAS_ARR);
    endsequence

    sequence wai_req_s;
        REQ_VALID && s_r.st == sbmc_pkg::ST_IDLE && !s_r.mav
            && REQ.cmd == sbmc_pkg::CMD_WAI;
    endsequence

    sequence dcl_busy_s;
        REQ_VALID && REQ.cmd == sbmc_pkg::CMD_DCL
            && (s_r.st != sbmc_pkg::ST_IDLE || s_r.mav);
    endsequence

    srq_masked_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
        SRQ == |($past(stb_comb) & $past(s_r.sre) & `SBMC_SRE_MASK))
        else $error("service request mismatch");
    bit_one_zero_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
        !STATUS_BYTE[1]) else $error("bit 1 set");
    mav_bit_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
        STATUS_BYTE[`SBMC_BIT_MAV] == $past(s_r.mav)) else $error("mav bit wrong");
    fetch_no_meas_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
        fetch_req_s |=> !ADC_START && s_r.fn == $past(s_r.fn)) else $error("fetch measured");
    acq_hold_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
        s_r.st == sbmc_pkg::ST_ACQ |-> !REQ_READY) else $error("ready while acquiring");
    talk_gate_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
        RESP.valid |-> $past(talk_s)) else $error("response without talk");
    lint_size_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
        s_r.st == sbmc_pkg::ST_ACQ && s_r.fn == sbmc_pkg::FN_LINT |-> s_r.size == 1)
        else $error("long integration size not one");
    tst_code_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
        REQ_VALID && REQ.cmd == sbmc_pkg::CMD_TST && s_r.st == sbmc_pkg::ST_IDLE && !s_r.mav
        |=> s_r.qdata == {31'h0, $past(ROM_FAIL)}) else $error("self-test code wrong");
    stb_bits_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
        $past(RSTN) |-> (STATUS_BYTE & 8'hAD) == {$past(EVT.oper_event), 1'b0,
            $past(EVT.std_event), 1'b0, $past(EVT.ques_event), $past(EVT.err_nonempty),
            1'b0, $past(EVT.meas_event)}) else $error("summary bits wrong");
    rqs_bit_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
        SRQ == STATUS_BYTE[`SBMC_BIT_RQS]) else $error("request bit differs");
    trg_start_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
        trg_req_s |=> ADC_START && s_r.trg_only) else $error("trigger did not start");
    read_start_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
        read_req_s |=> ADC_START && !REQ_READY && s_r.st == sbmc_pkg::ST_ACQ)
        else $error("read did not start");
    wai_noop_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
        wai_req_s |=> !ADC_START ##1 !STATUS_BYTE[`SBMC_BIT_MAV])
        else $error("wait had effect");
    dcl_abort_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
        dcl_busy_s |=> s_r.st == sbmc_pkg::ST_IDLE && !s_r.mav) else $error("clear ignored");
endmodule : sbmc_top

/* hw/sbmc_consts.svh */
// Offsets, field positions, reset values and counts for the status and measure block
`ifndef SBMC_CONSTS_SVH
`define SBMC_CONSTS_SVH
`define SBMC_BIT_MEAS      0
`define SBMC_BIT_ERRQ      2
`define SBMC_BIT_QUES      3
`define SBMC_BIT_MAV       4
`define SBMC_BIT_ESB       5
`define SBMC_BIT_RQS       6
`define SBMC_BIT_OPER      7
`define SBMC_SRE_MASK      8'hBF
`define SBMC_SRE_RESET     8'h00
`define SBMC_AVG_RESET     7'h01
`define SBMC_TST_PASS      32'h00000000
`define SBMC_TST_FAIL      32'h00000001
`define SBMC_LINT_SIZE     7'h01
`endif

/* hw/sbmc_pkg.sv */
// Types for the status byte and measure command block
package sbmc_pkg;
    typedef enum logic [3:0] {
        CMD_NONE, CMD_STB, CMD_TRG, CMD_TST, CMD_WAI, CMD_FETCH, CMD_FETCH_ARR,
        CMD_READ, CMD_READ_ARR, CMD_MEAS, CMD_MEAS_ARR, CMD_SRE, CMD_DCL
    } sbmc_cmd_t;
    typedef enum logic [2:0] {
        FN_VOLT, FN_CURR, FN_PCURR, FN_DVM, FN_LINT, FN_KEEP
    } sbmc_fn_t;
    typedef enum logic [1:0] {
        ST_IDLE, ST_ACQ, ST_RESP
    } sbmc_state_t;
    typedef struct packed {
        sbmc_cmd_t  cmd;
        sbmc_fn_t   fn;
        logic [7:0] arg;
    } sbmc_req_t;
    typedef struct packed {
        logic        meas_event;
        logic        err_nonempty;
        logic        ques_event;
        logic        std_event;
        logic        oper_event;
    } sbmc_evt_t;
    typedef struct packed {
        logic        valid;
        logic [31:0] data;
        logic        last;
    } sbmc_resp_t;
endpackage : sbmc_pkg

/* hw/sbmc_summary.sv */
// Combinational status summary byte builder
`timescale 1ns/1ns
`include "sbmc_consts.svh"
module sbmc_summary (
    input  wire sbmc_pkg::sbmc_evt_t evt,
    input  wire logic                mav,
    input  wire logic [7:0]          sre,
    output logic [7:0]               stb
);
    logic [7:0] raw;
    always_comb
    begin
        raw                   = 8'h00;
        raw[`SBMC_BIT_MEAS]   = evt.meas_event;
        raw[`SBMC_BIT_ERRQ]   = evt.err_nonempty;
        raw[`SBMC_BIT_QUES]   = evt.ques_event;
        raw[`SBMC_BIT_MAV]    = mav;
        raw[`SBMC_BIT_ESB]    = evt.std_event;
        raw[`SBMC_BIT_OPER]   = evt.oper_event;
        stb                   = raw;
        stb[`SBMC_BIT_RQS]    = |(raw & sre & `SBMC_SRE_MASK);
    end
endmodule : sbmc_summary

/* sim/sbmc_host_model.sv */
// Host controller and converter model facing the status and measure block
`timescale 1ns/1ns
module sbmc_host_model (
    input  wire logic        clk,
    input  wire logic        talk_en,
    input  wire logic [3:0]  dly,
    input  wire logic        adc_start,
    output logic             talk,
    output logic             adc_done,
    output logic [31:0]      adc_data
);
    logic [3:0]  wait_r = 4'h0;
    logic        busy_r = 1'b0;
    logic [31:0] k_r    = 32'h0;
    // Host addresses the device to talk only when it wants data
    assign talk = talk_en;
    initial
    begin
        adc_done = 1'b0;
        adc_data = 32'h0;
    end
    // Converter answers each start dly+1 cycles later
    always @(posedge clk)
    begin
        adc_done <= 1'b0;
        adc_data <= ~adc_data;
        if (adc_start)
        begin
            busy_r <= 1'b1;
            wait_r <= dly;
        end
        else if (busy_r && wait_r != 4'h0)
            wait_r <= wait_r - 4'h1;
        else if (busy_r)
        begin
            busy_r   <= 1'b0;
            adc_done <= 1'b1;
            adc_data <= (k_r + 32'h1) * 32'h4;
            k_r      <= k_r + 32'h1;
        end
    end
endmodule : sbmc_host_model

/* sim/status_byte_and_measure_cmds_test.sv */
// Self-checking bench for the status and measure block
`timescale 1ns/1ns
module status_byte_and_measure_cmds_test;
    logic                 CLOCK, RSTN, REQ_VALID, ROM_FAIL, ADC_DONE, TALK;
    sbmc_pkg::sbmc_req_t  REQ;
    sbmc_pkg::sbmc_evt_t  EVT;
    logic [6:0]           AVG_COUNT;
    logic [31:0]          ADC_DATA;
    logic                 REQ_READY, ADC_START, DISP_STROBE, SRQ;
    sbmc_pkg::sbmc_fn_t   FUNC_SEL;
    sbmc_pkg::sbmc_resp_t RESP;
    logic [7:0]           STATUS_BYTE;
    logic                 talk_en;
    logic [3:0]           dly;
    logic [31:0]          q[$];
    int                   fail_count, cmp_count, starts, strobes, s, d, i, j;
    sbmc_pkg::sbmc_fn_t   fns[5];
    logic [20:0]          rows[7];
    sbmc_top i_dut (.CLOCK(CLOCK), .RSTN(RSTN), .REQ(REQ), .REQ_VALID(REQ_VALID),
        .EVT(EVT), .AVG_COUNT(AVG_COUNT), .ROM_FAIL(ROM_FAIL), .ADC_DONE(ADC_DONE),
        .ADC_DATA(ADC_DATA), .TALK(TALK), .REQ_READY(REQ_READY), .ADC_START(ADC_START),
        .DISP_STROBE(DISP_STROBE), .FUNC_SEL(FUNC_SEL), .RESP(RESP),
        .STATUS_BYTE(STATUS_BYTE), .SRQ(SRQ));
    sbmc_host_model i_host (.clk(CLOCK), .talk_en(talk_en), .dly(dly),
        .adc_start(ADC_START), .talk(TALK), .adc_done(ADC_DONE), .adc_data(ADC_DATA));
    // ----
    // Helpers
    // ----
    initial
    begin
        CLOCK = 1'b0;
        forever #5 CLOCK = ~CLOCK;
    end
    always @(posedge CLOCK)
    begin
        starts  += (ADC_START === 1'b1);
        strobes += (DISP_STROBE === 1'b1);
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task send(input sbmc_pkg::sbmc_cmd_t c, input sbmc_pkg::sbmc_fn_t f, input logic [7:0] a);
        int n;
        n = 0;
        while ((REQ_READY !== 1'b1 || STATUS_BYTE[4] !== 1'b0) && n < 500)
        begin
            @(negedge CLOCK);
            n++;
        end
        chk(n < 500, 1'b1);
        REQ       = '{cmd: c, fn: f, arg: a};
        REQ_VALID = 1'b1;
        @(negedge CLOCK);
        REQ_VALID = 1'b0;
    endtask : send
    task get();
        int n;
        q.delete();
        n = 0;
        while (STATUS_BYTE[4] !== 1'b1 && n < 500)
        begin
            @(negedge CLOCK);
            n++;
        end
        chk(STATUS_BYTE[4], 1'b1);
        talk_en = 1'b1;
        for (n = 0; n < 300; n++)
        begin
            @(negedge CLOCK);
            if (RESP.valid === 1'b1)
                q.push_back(RESP.data);
            if (RESP.valid === 1'b1 && RESP.last === 1'b1)
                break;
        end
        chk(n < 300, 1'b1);
        talk_en = 1'b0;
        repeat (3) @(negedge CLOCK);
    endtask : get
    task finish_test();
        $display("checks=%0d mismatches=%0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test
    initial
    begin
        #300000;
        fail_count++;
        finish_test();
    end
    // ----
    // Main sequence
    // ----
    initial
    begin
        {RSTN, REQ_VALID, ROM_FAIL, talk_en, fail_count, cmp_count, starts, strobes} = '0;
        REQ = '0;
        EVT = '0;
        AVG_COUNT = 7'h01;
        dly = 4'h2;
        fns = '{sbmc_pkg::FN_CURR, sbmc_pkg::FN_PCURR, sbmc_pkg::FN_DVM,
                sbmc_pkg::FN_VOLT, sbmc_pkg::FN_LINT};
        rows = '{{5'h10, 8'h00, 8'h01}, {5'h08, 8'h04, 8'h44}, {5'h04, 8'h01, 8'h08},
                 {5'h02, 8'h20, 8'h60}, {5'h01, 8'hFF, 8'hC0}, {5'h1F, 8'h08, 8'hED},
                 {5'h00, 8'hFF, 8'h00}};
        repeat (5) @(negedge CLOCK);
        RSTN = 1'b1;
        repeat (2) @(negedge CLOCK);
        chk({STATUS_BYTE, REQ_READY}, 9'h001);
        chk(FUNC_SEL, sbmc_pkg::FN_VOLT);
        for (i = 0; i < 7; i++)
        begin
            EVT = rows[i][20:16];
            send(sbmc_pkg::CMD_SRE, sbmc_pkg::FN_KEEP, rows[i][15:8]);
            repeat (3) @(negedge CLOCK);
            chk({SRQ, STATUS_BYTE}, {rows[i][6], rows[i][7:0]});
        end
        EVT = 5'h14;
        for (i = 0; i < 2; i++)
        begin
            send(sbmc_pkg::CMD_STB, sbmc_pkg::FN_KEEP, 8'h00);
            get();
            chk(q[0] & 32'hEF, 32'h49);
            chk(STATUS_BYTE, 8'h49);
        end
        for (i = 0; i < 2; i++)
        begin
            ROM_FAIL = i[0];
            send(sbmc_pkg::CMD_TST, sbmc_pkg::FN_KEEP, 8'h00);
            get();
            chk(q[0], i);
        end
        s = starts;
        send(sbmc_pkg::CMD_WAI, sbmc_pkg::FN_KEEP, 8'h00);
        repeat (6) @(negedge CLOCK);
        chk({STATUS_BYTE, REQ_READY}, {8'h49, 1'b1});
        chk(starts - s, 0);
        AVG_COUNT = 7'h03;
        dly = 4'h8;
        s = starts;
        send(sbmc_pkg::CMD_READ, sbmc_pkg::FN_KEEP, 8'h00);
        @(negedge CLOCK);
        REQ       = '{cmd: sbmc_pkg::CMD_TST, fn: sbmc_pkg::FN_KEEP, arg: 8'h00};
        REQ_VALID = 1'b1;
        @(negedge CLOCK);
        REQ_VALID = 1'b0;
        get();
        chk(q.size(), 1);
        chk(q[0], 4 * (s + 2));
        chk(starts - s, 3);
        chk(STATUS_BYTE[4], 1'b0);
        d = starts;
        send(sbmc_pkg::CMD_FETCH, sbmc_pkg::FN_KEEP, 8'h00);
        get();
        chk(q[0], 4 * (s + 2));
        chk(starts - d, 0);
        chk(FUNC_SEL, sbmc_pkg::FN_VOLT);
        dly = 4'h0;
        s = starts;
        for (i = 0; i < 2; i++)
        begin
            send(i ? sbmc_pkg::CMD_FETCH_ARR : sbmc_pkg::CMD_READ_ARR, sbmc_pkg::FN_KEEP, 8'h0);
            get();
            chk(q.size(), 3);
            for (j = 0; j < 3; j++)
                chk(q[j], 4 * (s + 1 + j));
        end
        AVG_COUNT = 7'h01;
        d = strobes;
        s = starts;
        send(sbmc_pkg::CMD_TRG, sbmc_pkg::FN_KEEP, 8'h00);
        repeat (20) @(negedge CLOCK);
        chk(strobes - d, 1);
        chk(starts - s, 1);
        chk(STATUS_BYTE[4], 1'b0);
        AVG_COUNT = 7'h02;
        for (i = 0; i < 5; i++)
        begin
            send(sbmc_pkg::CMD_MEAS_ARR, fns[i], 8'h00);
            get();
            chk(FUNC_SEL, fns[i]);
            chk(q.size(), (i == 4) ? 1 : 2);
        end
        send(sbmc_pkg::CMD_MEAS, sbmc_pkg::FN_KEEP, 8'h00);
        get();
        chk(FUNC_SEL, sbmc_pkg::FN_LINT);
        chk(q.size(), 1);
        send(sbmc_pkg::CMD_FETCH_ARR, sbmc_pkg::FN_KEEP, 8'h00);
        get();
        chk(q.size(), 1);
        AVG_COUNT = 7'h03;
        dly = 4'h8;
        d = strobes;
        send(sbmc_pkg::CMD_MEAS, sbmc_pkg::FN_VOLT, 8'h00);
        @(negedge CLOCK);
        REQ       = '{cmd: sbmc_pkg::CMD_DCL, fn: sbmc_pkg::FN_KEEP, arg: 8'h00};
        REQ_VALID = 1'b1;
        @(negedge CLOCK);
        REQ_VALID = 1'b0;
        repeat (40) @(negedge CLOCK);
        chk({REQ_READY, STATUS_BYTE[4]}, 2'h2);
        chk(strobes - d, 0);
        chk(FUNC_SEL, sbmc_pkg::FN_VOLT);
        send(sbmc_pkg::CMD_STB, sbmc_pkg::FN_KEEP, 8'h00);
        repeat (4) @(negedge CLOCK);
        chk(STATUS_BYTE[4], 1'b1);
        REQ       = '{cmd: sbmc_pkg::CMD_DCL, fn: sbmc_pkg::FN_KEEP, arg: 8'h00};
        REQ_VALID = 1'b1;
        @(negedge CLOCK);
        REQ_VALID = 1'b0;
        repeat (4) @(negedge CLOCK);
        chk({REQ_READY, STATUS_BYTE[4]}, 2'h2);
        finish_test();
    end
endmodule : status_byte_and_measure_cmds_test
